// ===== hdl/scpb_defines.vh
/*
 Constants of the clock prescale and multiplier block: register offsets, field positions,
 reset values, oscillator mode codes and the ratios of the multiplier chain.
 Assumes it is included once per compilation unit by its bare name.
*/
`ifndef SCPB_DEFINES_VH
`define SCPB_DEFINES_VH

// Register byte offsets on the AHB-Lite bus.
`define SCPB_CTRL_OFS 8'h00
`define SCPB_STAT_OFS 8'h04

// Control register fields.
`define SCPB_POST_RATIO_BIT 7
`define SCPB_MULT_EN_BIT 6
`define SCPB_POST_EN_BIT 5
`define SCPB_PRE_RATIO_BIT 4
`define SCPB_CTRL_RESET 4'h0

// Primary oscillator mode codes on the low two configuration bits.
`define SCPB_MODE_HS 2'h0
`define SCPB_MODE_HS_MULT 2'h1
`define SCPB_MODE_EXT 2'h2
`define SCPB_MODE_EXT_MULT 2'h3

// Ratios of the chain.
`define SCPB_MULT_FACTOR 5'h05
`define SCPB_PRE_DIV_A 5'h02
`define SCPB_PRE_DIV_B 5'h03
`define SCPB_POST_DIV_A 5'h02
`define SCPB_POST_DIV_B 5'h03
`define SCPB_CLKOUT_DIV 2'h3

`endif

// ===== hdl/scpb_clock_block.v
/*
 Clock generation control: primary oscillator mode decode, divided-by-four clock output,
 slow internal oscillator enable, and the prescaler, multiplier and postscaler chain with
 its control register on AHB-Lite.
 Assumes clk runs well above the primary clock so that each primary edge is seen, and that
 the configuration inputs are steady after config_loaded rises.
*/
`timescale 1ns/1ps
`include "scpb_defines.vh"

// What this block does
// - Plain external-clock mode drives the output pin with input clock divided by four.
// - Both external-clock modes request no oscillator start-up wait.
// - Slow internal oscillator runs from power-up through the configuration cycle.
// - Slow oscillator also runs when selected, or monitor, watchdog or two-speed on.
// - A configuration bit makes the slow oscillator the default start-up clock.
// - Prescaler divides by 2 when its ratio bit is 1, by 3 when 0.
// - Multiplier enable bit turns on the times-five multiplier of the prescaled clock.
// - Postscaler passes 1:1 when disabled, else divides by 2 or 3 per ratio bit.
// - Multiplier enable works only in multiplier modes, otherwise reads zero.
// - Multiplier and postscaler both off bypass the prescaler; clock equals primary.
// - Multiplier-on settings give 31.25, 41.67, 20.83 and 13.89 MHz from 25 MHz.
// - Multiplier-off settings give 6.25, 4.17 and 2.78 MHz from 25 MHz.
// - Feedback path stays on in crystal modes and is off in external-clock modes.
// - Low two configuration bits pick the mode; a third picks default slow clock.
module scpb_clock_block (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // AHB-Lite slave.
   input wire hsel,
   input wire [7:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // Configuration.
   input wire [1:0] osc_mode_config,
   input wire default_source_config_bit,
   input wire config_loaded,
   input wire fail_safe_monitor_en,
   input wire watchdog_en,
   input wire two_speed_startup_en,
   // Oscillator pins.
   input wire clock_input_pin,
   output reg clock_output_pin,
   output reg clock_output_pin_oe,
   // Oscillator and system clock controls.
   output reg feedback_enable,
   output reg startup_wait_enable,
   output reg slow_osc_enable,
   output reg slow_osc_is_clock,
   output reg sys_clk_tick
);

   reg [3:0] ctrl_q;
   reg [3:0] ctrl_d;
   reg [1:0] mode_q;
   reg default_source_config_bit_q;
   reg cfg_done_q;
   reg wr_pend_q;
   reg [7:0] wr_addr_q;
   reg pin_s1_q;
   reg pin_s2_q;
   reg pin_s3_q;
   reg [1:0] div4_q;
   reg [4:0] credit_q;
   reg [4:0] num_q;
   reg [4:0] den_q;
   reg [4:0] credit_add;
   reg [4:0] new_num;
   reg [4:0] new_den;
   reg [4:0] pre_div;
   reg [4:0] post_div;
   reg [31:0] rd_val;
   wire mult_mode;
   wire ext_mode;
   wire prim_edge;
   wire addr_ok;
   wire tick_now;
   wire [7:0] ctrl_rd;

   assign mult_mode = (mode_q == `SCPB_MODE_HS_MULT) || (mode_q == `SCPB_MODE_EXT_MULT);
   assign ext_mode = (mode_q == `SCPB_MODE_EXT) || (mode_q == `SCPB_MODE_EXT_MULT);
   assign prim_edge = pin_s2_q & ~pin_s3_q;
   assign addr_ok = hsel & htrans[1] & hready;
   // The multiplier bit is hidden outside the multiplier modes.
   assign ctrl_rd = {ctrl_d[3], ctrl_d[2] & mult_mode, ctrl_d[1:0], 4'h0};

   // Register write in the data phase, bit 6 kept only in multiplier modes.
   always @* begin
      ctrl_d = ctrl_q;
      if (wr_pend_q && wr_addr_q == `SCPB_CTRL_OFS) begin
         ctrl_d = hwdata[7:4];
         ctrl_d[2] = hwdata[`SCPB_MULT_EN_BIT] & mult_mode;
      end
   end

   always @* begin
      rd_val = 32'h0000_0000;
      case (haddr)
         `SCPB_CTRL_OFS: rd_val = {24'h00_0000, ctrl_rd};
         `SCPB_STAT_OFS: rd_val = {18'h0_0000, den_q, num_q, slow_osc_is_clock,
            feedback_enable, mode_q};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Chain ratios from the control bits.
   always @* begin
      pre_div = ctrl_q[0] ? `SCPB_PRE_DIV_A : `SCPB_PRE_DIV_B;
      post_div = 5'h01;
      if (ctrl_q[1]) begin
         post_div = ctrl_q[3] ? `SCPB_POST_DIV_A : `SCPB_POST_DIV_B;
      end
      new_num = (ctrl_q[2] & mult_mode) ? `SCPB_MULT_FACTOR : 5'h01;
      new_den = pre_div * post_div;
      if (!ctrl_q[2] && !ctrl_q[1]) begin
         new_den = 5'h01;
      end
      credit_add = prim_edge ? num_q : 5'h00;
   end

   // A tick is due when the credit, num_q per primary edge, reaches the divide ratio.
   assign tick_now = (credit_q >= den_q);

   always @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         ctrl_q <= `SCPB_CTRL_RESET;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         ctrl_q <= ctrl_d;
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_q <= haddr;
         end
         if (addr_ok && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   // Configuration capture at the end of the configuration cycle.
   always @(posedge clk) begin
      if (rst) begin
         mode_q <= `SCPB_MODE_HS;
         default_source_config_bit_q <= 1'b1;
         cfg_done_q <= 1'b0;
      end else if (config_loaded && !cfg_done_q) begin
         mode_q <= osc_mode_config;
         default_source_config_bit_q <= default_source_config_bit;
         cfg_done_q <= 1'b1;
      end
   end

   // Primary clock synchroniser and rate chain.
   always @(posedge clk) begin
      if (rst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
         div4_q <= 2'h0;
         credit_q <= 5'h00;
         num_q <= 5'h01;
         den_q <= 5'h01;
         sys_clk_tick <= 1'b0;
      end else begin
         pin_s1_q <= clock_input_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (prim_edge) begin
            div4_q <= div4_q + 2'h1;
         end
         sys_clk_tick <= tick_now;
         if (tick_now) begin
            credit_q <= credit_q - den_q + credit_add;
         end else begin
            credit_q <= credit_q + credit_add;
         end
         if (tick_now || credit_q == 5'h00) begin
            num_q <= new_num;
            den_q <= new_den;
         end
      end
   end

   // Pin and oscillator controls.
   always @(posedge clk) begin
      if (rst) begin
         clock_output_pin <= 1'b0;
         clock_output_pin_oe <= 1'b0;
         feedback_enable <= 1'b1;
         startup_wait_enable <= 1'b1;
         slow_osc_enable <= 1'b1;
         slow_osc_is_clock <= 1'b1;
      end else begin
         clock_output_pin_oe <= (mode_q == `SCPB_MODE_EXT);
         clock_output_pin <= (mode_q == `SCPB_MODE_EXT) & div4_q[1];
         feedback_enable <= ~ext_mode;
         startup_wait_enable <= ~ext_mode;
         slow_osc_is_clock <= ~cfg_done_q | ~default_source_config_bit_q;
         slow_osc_enable <= ~cfg_done_q | ~default_source_config_bit_q | fail_safe_monitor_en | watchdog_en
            | two_speed_startup_en;
      end
   end

endmodule // scpb_clock_block

// ===== bench/scpb_osc_src.sv
/* Free-running primary clock source that stands at the clock input pin.
   Assumes clk is faster than the source; half gives its half period in clk cycles. */
`timescale 1ns/1ps
module scpb_osc_src (
   // Bench clock and chosen half period.
   input wire clk,
   input wire [7:0] half,
   // Primary clock pin.
   output logic pin
);
   logic [7:0] cnt_q = 8'h00;
   initial pin = 1'h0;
   // The source never stops or changes rate, as a fixed crystal would not.
   always @(posedge clk) begin
      cnt_q <= (cnt_q + 8'h01 >= half) ? 8'h00 : cnt_q + 8'h01;
      if (cnt_q + 8'h01 >= half) begin
         pin <= ~pin;
      end
   end
endmodule // scpb_osc_src

// ===== bench/scpb_clock_block_chk.sv
/* Port assertions of the clock prescale block.
   Assumes the single clock clk and the synchronous reset rst. */
`timescale 1ns/1ps
module scpb_clock_block_chk (
   // Clock, reset and bus answer.
   input wire clk,
   input wire rst,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   // Configuration and oscillator controls.
   input wire config_loaded,
   input wire fail_safe_monitor_en,
   input wire watchdog_en,
   input wire two_speed_startup_en,
   input wire clock_output_pin,
   input wire clock_output_pin_oe,
   input wire feedback_enable,
   input wire startup_wait_enable,
   input wire slow_osc_enable,
   input wire slow_osc_is_clock
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_BUS: assert property (hreadyout && !hresp)
      else $error("bus answer is not zero wait OKAY");
   AST_HIGH: assert property (hrdata[31:14] == 18'h0)
      else $error("unimplemented read bits not zero");
   AST_OE_FB: assert property (clock_output_pin_oe |-> !feedback_enable)
      else $error("feedback on while clock output driven");
   AST_NOWAIT: assert property (!feedback_enable |-> !startup_wait_enable)
      else $error("start-up wait in external clock mode");
   AST_SLOW_SEL: assert property (slow_osc_is_clock |-> slow_osc_enable)
      else $error("selected slow oscillator not running");
   AST_SLOW_FEAT: assert property ((fail_safe_monitor_en || watchdog_en || two_speed_startup_en)
      |=> slow_osc_enable)
      else $error("slow oscillator off while a feature needs it");
   AST_PWRUP: assert property (!config_loaded |=> slow_osc_is_clock)
      else $error("slow oscillator not the clock before config");
   AST_CLKOUT: assert property ($changed(clock_output_pin) |=> $stable(clock_output_pin)[*8])
      else $error("clock output toggles too fast");
endmodule // scpb_clock_block_chk
bind scpb_clock_block scpb_clock_block_chk u_chk (.*);

// ===== bench/scpb_clock_block_tb.sv
/* Self-checking bench of the clock prescale block and its control register.
   Assumes the design, the checker and the source model are compiled before it. */
`timescale 1ns/1ps
module scpb_clock_block_tb;
   logic clk = 1'h0, rst = 1'h1, hsel = 1'h1, hwrite = 1'h0, config_loaded = 1'h0;
   logic default_source_config_bit = 1'h1, fail_safe_monitor_en = 1'h0;
   logic watchdog_en = 1'h0, two_speed_startup_en = 1'h0, clock_input_pin;
   logic [1:0] htrans = 2'h0, osc_mode_config = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, clock_output_pin, clock_output_pin_oe, feedback_enable;
   logic startup_wait_enable, slow_osc_enable, slow_osc_is_clock, sys_clk_tick;
   wire hready = hreadyout;
   int failures = 0, num_checks = 0;
   scpb_clock_block u_dut (.*);
   scpb_osc_src u_src (.clk(clk), .half(8'h0a), .pin(clock_input_pin));
   always #25 clk = ~clk;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask
   task automatic boot(input logic [1:0] m, input logic b);
      @(posedge clk);
      rst <= 1'h1;
      config_loaded <= 1'h0;
      osc_mode_config <= m;
      default_source_config_bit <= b;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      config_loaded <= 1'h1;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_slow;
      boot(2'h0, 1'h0);
      chk("sel", {slow_osc_is_clock, slow_osc_enable, feedback_enable}, 3'h7);
      bus(1'h1, 8'h00, 32'h40);
      bus(1'h0, 8'h00, 32'h0);
      chk("mask0", rd, 32'h0);
      boot(2'h1, 1'h1);
      bus(1'h0, 8'h00, 32'h0);
      chk("rst", rd, 32'h0);
      chk("off", {slow_osc_is_clock, slow_osc_enable}, 2'h0);
      for (int i = 1; i < 8; i = i * 2) begin
         {fail_safe_monitor_en, watchdog_en, two_speed_startup_en} <= i[2:0];
         repeat (3) @(posedge clk);
         chk("feat", slow_osc_enable, 1'h1);
      end
      {fail_safe_monitor_en, watchdog_en, two_speed_startup_en} <= 3'h0;
      bus(1'h1, 8'h00, 32'h40);
      bus(1'h0, 8'h04, 32'h0);
      chk("stat1", rd[3:0], 4'h5);
   endtask
   task automatic t_ext;
      int k;
      logic p;
      boot(2'h2, 1'h1);
      bus(1'h1, 8'h00, 32'hf0);
      bus(1'h0, 8'h00, 32'h0);
      chk("mask2", rd, 32'hb0);
      chk("pins", {clock_output_pin_oe, feedback_enable, startup_wait_enable}, 3'h4);
      bus(1'h1, 8'h08, 32'hff);
      bus(1'h0, 8'h08, 32'h0);
      chk("hole", rd, 32'h0);
      p = clock_output_pin;
      k = 0;
      repeat (1600) begin
         @(posedge clk);
         k += (clock_output_pin != p);
         p = clock_output_pin;
      end
      // Input period is 20 cycles, so the output toggles every 40.
      chk("div4", k > 38 && k < 42, 1'h1);
   endtask
   task automatic t_rates;
      logic [4:0] f, d;
      int k;
      boot(2'h3, 1'h1);
      for (int n = 0; n < 16; n++) begin
         // Software never selects the reserved multiplier-on, divide-by-2, no-post setting.
         if (n[2:0] == 3'h5) continue;
         f = n[2] ? 5'h05 : 5'h01;
         d = (n[0] ? 5'h02 : 5'h03) * (n[1] ? (n[3] ? 5'h02 : 5'h03) : 5'h01);
         if (n[2:1] == 2'h0) d = 5'h01;
         bus(1'h1, 8'h00, n << 4);
         repeat (400) @(posedge clk);
         bus(1'h0, 8'h04, 32'h0);
         chk("stat", rd, {18'h0, d, f, 4'h3});
         k = 0;
         repeat (1800) @(posedge clk) k += sys_clk_tick;
         // 1800 cycles hold 90 input edges; allow two ticks of credit slack.
         chk("rate", k * d > 90 * f - 2 * d && k * d < 90 * f + 2 * d, 1'h1);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      t_slow;
      t_ext;
      t_rates;
      stop_test;
   end
   // The tests take about 35000 cycles; cut off at 60000.
   initial begin
      #3000000;
      failures++;
      stop_test;
   end
endmodule // scpb_clock_block_tb
